// ===== ees_slave.sv
// serial slave front end with its byte-wide array
// assumes scl/sda come from pins of another domain; straps tie low if floating
`timescale 1ns/1ps
`default_nettype none
module ees_slave
    import ees_pkg::*;
#(
    parameter int DEPTH = EES_DEPTH_DEF,
    parameter int PROG_CYC = EES_PROG_CYC
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic write_protect_input,
    output logic busy
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // refused at elaboration so no build runs with a size it cannot serve
    if (DEPTH != 4096 && DEPTH != 8192 && DEPTH != 16384)
    begin : g_bad_depth
        $error("depth must be 4096, 8192 or 16384");
    end
    if (PROG_CYC < 1)
    begin : g_bad_prog
        $error("program time too short");
    end
    // edge detect needs several system clocks per bus clock phase
    if (EES_CLK_HZ < 10 * EES_BUS_MAX_HZ)
    begin : g_slow_clk
        $error("system clock too slow for bus rate");
    end

    // ------------------------------------------------------------
    // synchronisers and edge detect
    // ------------------------------------------------------------
    ees_bus_s s1_r, s2_r, s3_r;
    logic [1:0] wp_r;
    logic [2:0] strap_s1_r, strap_r;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s1_r <= '{scl: 1'b1, sda: 1'b1};
            s2_r <= '{scl: 1'b1, sda: 1'b1};
            s3_r <= '{scl: 1'b1, sda: 1'b1};
            wp_r <= 2'h0;
            strap_s1_r <= 3'h0;
            strap_r <= 3'h0;
        end
        else
        begin
            s1_r <= '{scl: scl_i, sda: sda_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
            wp_r <= {wp_r[0], write_protect_input};
            strap_s1_r <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            strap_r <= strap_s1_r;
        end
    end

    // straps are synchronised like any pin; an unconnected pin is pulled
    // low outside and the flops reset low, so floating straps give zero
    logic [2:0] strap;
    assign strap = strap_r;

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = s2_r.scl && !s3_r.scl;
    assign scl_fall = !s2_r.scl && s3_r.scl;
    assign start_c = s2_r.scl && s3_r.scl && s3_r.sda && !s2_r.sda;
    assign stop_c = s2_r.scl && s3_r.scl && !s3_r.sda && s2_r.sda;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] mem_r [DEPTH];
    logic [AW-1:0] ptr_r;
    logic [7:0] wbuf_r;
    logic wpend_r;

    // ------------------------------------------------------------
    // bit engine and state machine
    // ------------------------------------------------------------
    ees_state_e st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic ack_r;
    logic rd_r;
    logic [31:0] prog_r;
    logic [7:0] byte_in;
    assign byte_in = {sh_r[6:0], s2_r.sda};

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_r <= EES_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ack_r <= 1'b0;
            rd_r <= 1'b0;
            prog_r <= 32'h0;
            ptr_r <= '0;
            wbuf_r <= 8'h00;
            wpend_r <= 1'b0;
        end
        else if (st_r == EES_PROG)
        begin
            // bus is ignored entirely while programming
            if (prog_r == 32'h0)
                st_r <= EES_IDLE;
            else
                prog_r <= prog_r - 32'h1;
        end
        else if (stop_c)
        begin
            ack_r <= 1'b0;
            if (wpend_r)
            begin
                st_r <= EES_PROG;
                prog_r <= 32'(PROG_CYC - 1);
                wpend_r <= 1'b0;
            end
            else
                st_r <= EES_IDLE;
        end
        else if (start_c)
        begin
            st_r <= EES_SEL;
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            wpend_r <= 1'b0;
        end
        else if (st_r != EES_IDLE)
        begin
            if (scl_rise && bit_r < 4'h8)
            begin
                sh_r <= byte_in;
                bit_r <= bit_r + 4'h1;
            end
            else if (scl_rise && bit_r == 4'h9)
            begin
                // ninth clock high: in read the master's ack decides
                // whether another byte follows
                if (st_r == EES_RDATA && s2_r.sda)
                    st_r <= EES_IDLE;
            end
            else if (scl_fall && bit_r == 4'h8 && !ack_r)
            begin
                ack_r <= 1'b0;
                unique case (st_r)
                    EES_SEL:
                    begin
                        if (sh_r[7:4] == EES_TYPE_ID
                            && sh_r[3:1] == strap)
                        begin
                            ack_r <= 1'b1;
                            rd_r <= sh_r[0];
                        end
                        else
                            st_r <= EES_IDLE;
                    end
                    EES_ADDR_HI, EES_ADDR_LO:
                    begin
                        ack_r <= 1'b1;
                        if (st_r == EES_ADDR_HI)
                            ptr_r <= AW'({sh_r, ptr_r[7:0]});
                        else
                            ptr_r <= AW'({ptr_r[AW-1:8], sh_r});
                    end
                    EES_WDATA:
                    begin
                        if (!wp_r[1])
                        begin
                            ack_r <= 1'b1;
                            wbuf_r <= sh_r;
                            wpend_r <= 1'b1;
                        end
                    end
                    EES_RDATA:
                    begin
                        // step before the ninth clock so a no-ack that ends
                        // the read still leaves the next address in place
                        ack_r <= 1'b0;
                        ptr_r <= ptr_r + AW'(1);
                    end
                    default:
                        st_r <= EES_IDLE;
                endcase
                bit_r <= 4'h9;
            end
            else if (scl_fall && bit_r == 4'h8)
                bit_r <= 4'h9;
            else if (scl_fall && bit_r == 4'h9)
            begin
                // end of ninth clock: release and move to the next byte
                ack_r <= 1'b0;
                bit_r <= 4'h0;
                if (wpend_r)
                    ptr_r <= ptr_r + AW'(1);
                unique case (st_r)
                    EES_SEL:
                        st_r <= rd_r ? EES_RDATA : EES_ADDR_HI;
                    EES_ADDR_HI:
                        st_r <= EES_ADDR_LO;
                    EES_ADDR_LO:
                        st_r <= EES_WDATA;
                    EES_RDATA:
                        st_r <= EES_RDATA;
                    default:
                        st_r <= st_r;
                endcase
            end
        end
    end

    // single byte buffered; written into the array when programming starts
    always_ff @(posedge clk)
    begin
        if (st_r != EES_PROG && stop_c && wpend_r && !wp_r[1])
            mem_r[ptr_r - AW'(1)] <= wbuf_r;
    end

    // ------------------------------------------------------------
    // open-drain data output
    // ------------------------------------------------------------
    logic drive_nxt;
    always_comb
    begin
        drive_nxt = 1'b0;
        if (ack_r)
            drive_nxt = 1'b1;
        else if (st_r == EES_RDATA && bit_r < 4'h8)
            drive_nxt = !mem_r[ptr_r][3'(7 - bit_r)];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            // change data only while clock is low: releasing the line with
            // clock high would look like a stop to every device on the bus
            if (!s2_r.scl)
                sda_oe <= drive_nxt;
            sda_o <= 1'b0;
            busy <= (st_r == EES_PROG);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    drive_low_a: assert property (@(posedge clk)
        disable iff (!rstn) sda_o == 1'b0)
        else $error("data output not low");
    prog_quiet_a: assert property (@(posedge clk)
        disable iff (!rstn) st_r == EES_PROG && start_c |=> st_r != EES_SEL)
        else $error("bus served in program");
    bad_sel_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r == EES_SEL && scl_fall && bit_r == 4'h8 && !stop_c && !start_c
        && sh_r[7:4] != EES_TYPE_ID |=> st_r == EES_IDLE && !ack_r)
        else $error("wrong type acked");
    strap_miss_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r == EES_SEL && scl_fall && bit_r == 4'h8 && !stop_c && !start_c
        && sh_r[3:1] != strap |=> !ack_r)
        else $error("strap mismatch acked");
    start_det_a: assert property (@(posedge clk)
        disable iff (!rstn)
        start_c && !stop_c && st_r != EES_PROG
        |=> st_r == EES_SEL && bit_r == 4'h0)
        else $error("start missed");
    wp_nack_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r == EES_WDATA && wp_r[1] && scl_fall && bit_r == 4'h8
        && !start_c && !stop_c |=> !ack_r && !wpend_r)
        else $error("protected data acked");
    prog_enter_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r != EES_PROG && stop_c && wpend_r
        |=> st_r == EES_PROG ##1 busy)
        else $error("no program cycle");
    dir_read_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r == EES_SEL && ack_r && rd_r && scl_fall && bit_r == 4'h9
        && !start_c && !stop_c |=> st_r == EES_RDATA)
        else $error("read not entered");
    addr_ack_a: assert property (@(posedge clk)
        disable iff (!rstn)
        (st_r == EES_ADDR_HI || st_r == EES_ADDR_LO) && scl_fall
        && bit_r == 4'h8 && !ack_r && !start_c && !stop_c |=> ack_r)
        else $error("address byte not acked");
    ack_drive_a: assert property (@(posedge clk)
        disable iff (!rstn) ack_r && s2_r.scl |-> sda_oe)
        else $error("ack not on the line");
    rd_release_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r == EES_RDATA && bit_r == 4'h9 && s2_r.scl |-> !sda_oe)
        else $error("line held in master ack");
    sda_still_a: assert property (@(posedge clk)
        disable iff (!rstn) s2_r.scl |=> $stable(sda_oe))
        else $error("data moved with clock high");
    stop_idle_a: assert property (@(posedge clk)
        disable iff (!rstn)
        st_r != EES_PROG && stop_c && !wpend_r |=> st_r == EES_IDLE)
        else $error("stop not honoured");
endmodule
`default_nettype wire

// ===== ees_pkg.sv
// package for the serial memory slave front end
// assumes one 50 MHz system clock; bus pins are synchronised in the slave
// Functional notes
// - the array is byte wide with 4096, 8192 or 16384 locations by variant.
// - the device is only ever a slave, timed by the master's serial clock.
// - a transfer opens with start and a select byte, which is acked only on a type and strap match.
// - the select byte is answered only if its top nibble is the type code.
// - the device acknowledges matching select, address and unprotected data bytes in the ninth bit time.
// - the serial clock is only an input and times every data bit.
// - the data line is driven open-drain only: pulled low or released.
// - the three straps give the expected select code bits b3, b2 and b1.
// - a floating strap reads as low, so floating straps give address zero.
// - the slave logic works with bus clock rates up to 400 kHz.
// - write protect high blocks writes and no-acks data bytes only.
// - start is data falling, stop data rising, each with clock high.
// - the select byte is acknowledged only on a strap match, else standby.
// - the last select bit is direction: one read, zero write.
package ees_pkg;
    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    // type code value is arbitrary
    localparam logic [3:0] EES_TYPE_ID = 4'h5;
    localparam int EES_CLK_HZ = 50000000;
    localparam int EES_BUS_MAX_HZ = 400000;
    // program time in microseconds
    localparam int EES_PROG_US = 5000;
    localparam int EES_PROG_CYC = EES_PROG_US * (EES_CLK_HZ / 1000000);
    localparam int EES_DEPTH_DEF = 4096;

    typedef enum logic [2:0] {
        EES_IDLE, EES_SEL, EES_ADDR_HI, EES_ADDR_LO, EES_WDATA, EES_RDATA,
        EES_PROG
    } ees_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } ees_bus_s;
endpackage

// ===== ees_mst.sv
// bus master model: drives the serial clock and pulls the data line
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ees_mst (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    // ----------------------------------------------------------------
    // bit timing
    // ----------------------------------------------------------------
    // 160 ns bits; extra low time around each ninth bit gives the slave
    // room to release the line before the next rising clock
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic bit_io(input int gap, input logic b, output logic r);
        tick(2 + gap);
        sda_oe = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        tick(8);
        sda_oe = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(8);
        sda_oe = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b0;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io((i == 7) ? 6 : 0, b[i], r);
        bit_io(6, 1'b1, ack);
    endtask
    // last high sends no-ack so the slave stops driving
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io((i == 7) ? 6 : 0, 1'b1, r);
            d[i] = r;
        end
        bit_io(6, last, r);
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the serial memory slave front end
// assumes ees_mst drives the bus; the data line has a pull-up
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end end
module tb;
    import ees_pkg::*;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    // short program time keeps the run brief
    localparam int PROG = 200;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] strap = 3'h5;
    logic wp = 1'b0;
    logic scl, m_oe, sda_o, sda_oe, busy;
    logic [7:0] d;
    wire logic sda;
    int miscompares = 0;
    int checks_done = 0;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
    always #10 clk = ~clk;
    ees_mst m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
    ees_slave #(.DEPTH(4096), .PROG_CYC(PROG)) dut (
        .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .strap_addr_bit0(strap[0]),
        .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .write_protect_input(wp), .busy(busy));
    // ----------------------------------------------------------------
    // transfers
    // ----------------------------------------------------------------
    task automatic put(input logic [7:0] b, input logic e);
        logic a;
        m.put_byte(b, a);
        `CHK(a, ~e)
    endtask
    task automatic sel(input logic [2:0] s, input logic rw, input logic e);
        m.start();
        put({EES_TYPE_ID, s, rw}, e);
    endtask
    task automatic wr(input logic [7:0] dat, input logic e);
        sel(strap, 1'b0, 1'b1);
        put(8'h01, 1'b1);
        put(8'h23, 1'b1);
        put(dat, e);
        m.stop();
    endtask
    // address set by a write, then a repeated start turns to reading
    task automatic rd(output logic [7:0] dat);
        sel(strap, 1'b0, 1'b1);
        put(8'h01, 1'b1);
        put(8'h23, 1'b1);
        sel(strap, 1'b1, 1'b1);
        m.get_byte(1'b1, dat);
        m.stop();
    endtask
    task automatic idle_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(busy, 1'b0)
        wr(8'h3C, 1'b1);
        repeat (4) @(negedge clk);
        `CHK(busy, 1'b1)
        sel(3'h5, 1'b0, 1'b0);
        m.stop();
        idle_wait();
        rd(d);
        `CHK(d, 8'h3C)
        m.start();
        put({~EES_TYPE_ID, 3'h5, 1'b0}, 1'b0);
        m.stop();
        for (int i = 0; i < 3; i++)
        begin
            sel(3'h5 ^ (3'h1 << i), 1'b0, 1'b0);
            m.stop();
        end
        `CHK(busy, 1'b0)
        wp = 1'b1;
        wr(8'hA5, 1'b0);
        wp = 1'b0;
        idle_wait();
        rd(d);
        `CHK(d, 8'h3C)
        strap = 3'h0;
        rd(d);
        `CHK(d, 8'h3C)
        `CHK(sda_oe, 1'b0)
        `CHK(sda_o, 1'b0)
        stop_test();
    end
    // the whole sequence needs well under a quarter of this span
    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
